// ---- hw/pwmd_deadband.sv ----
`timescale 1ns/1ns

module pwmd_deadband import pwmd_pkg::*; #(
   parameter int COUNT_W = 7
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // control
   input wire logic enable,
   input wire logic [COUNT_W-1:0] count,
   // scheduled and delayed active level
   input wire logic sched,
   output logic actual
);

   logic [COUNT_W-1:0] cnt_reg; // cycles since scheduled activation
   logic [COUNT_W-1:0] cnt_next; // counter, next
   logic done; // programmed delay has elapsed

   // ------------------------------------------------------------
   // counter restarts whenever the scheduled level is inactive
   // ------------------------------------------------------------
   assign done = (cnt_reg >= count);
   assign cnt_next = (!sched) ? `PWMD_COUNT_RESET :
                     (done ? cnt_reg : cnt_reg + 1'b1);
   // only the rising edge is held back; falling passes at once
   assign actual = sched & (~enable | done);

   // counter register
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_reg <= `PWMD_COUNT_RESET;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking db_cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence db_rise_s;
      $rose(sched) && enable && count == 7'h3;
   endsequence

   sequence db_hold_s;
      (sched && enable && count == 7'h3) [*3];
   endsequence

   db_first_low_a: assert property (db_rise_s |-> !actual)
      else $error("dead-band output went active at once");
   db_release_a: assert property (db_rise_s ##1 db_hold_s |-> actual)
      else $error("dead-band output not released after count");
   db_bypass_a: assert property (!enable |-> actual == sched)
      else $error("delay applied outside half-bridge");
   db_fall_a: assert property (!sched |-> !actual)
      else $error("inactive edge was delayed");

endmodule : pwmd_deadband

// ---- hw/pwmd_pkg.sv ----
`include "pwmd_regs.svh"

package pwmd_pkg;

   // ------------------------------------------------------------
   // output configurations, in the order of their select encoding
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      pwmd_cfg_single,
      pwmd_cfg_half,
      pwmd_cfg_full_fwd,
      pwmd_cfg_full_rev
   } pwmd_cfg_type;

   // ------------------------------------------------------------
   // shared decode
   // ------------------------------------------------------------
   // any enabled source asserted (sources given active high)
   function automatic logic pwmd_src_hit(input logic [2:0] sel, input logic [2:0] src);
      pwmd_src_hit = |(sel & src);
   endfunction : pwmd_src_hit

   // pin level of a pair while shut down
   function automatic logic pwmd_shut_level(input logic [1:0] state);
      pwmd_shut_level = state[`PWMD_STATE_HIGH] & ~state[`PWMD_STATE_TRI];
   endfunction : pwmd_shut_level

endpackage : pwmd_pkg

// ---- hw/pwmd_regs.svh ----
`ifndef PWMD_REGS_SVH
`define PWMD_REGS_SVH

// ------------------------------------------------------------
// register offsets on the plain register port
// ------------------------------------------------------------
`define PWMD_DEL_ADDR 2'h0
`define PWMD_AS_ADDR 2'h1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PWMD_DEL_RESET 8'h00
`define PWMD_AS_RESET 8'h00
`define PWMD_COUNT_RESET 7'h00

// ------------------------------------------------------------
// field positions, dead-band / restart register
// ------------------------------------------------------------
`define PWMD_RESTART_BIT 7
`define PWMD_COUNT_MSB 6
`define PWMD_COUNT_LSB 0

// ------------------------------------------------------------
// field positions, auto-shutdown register
// ------------------------------------------------------------
`define PWMD_STATUS_BIT 7
`define PWMD_SRC_MSB 6
`define PWMD_SRC_LSB 4
`define PWMD_AC_MSB 3
`define PWMD_AC_LSB 2
`define PWMD_BD_MSB 1
`define PWMD_BD_LSB 0

// ------------------------------------------------------------
// bits inside the source-select and shutdown-state fields
// ------------------------------------------------------------
`define PWMD_SRC_CMP1 0
`define PWMD_SRC_CMP2 1
`define PWMD_SRC_FAULT 2
`define PWMD_STATE_TRI 1
`define PWMD_STATE_HIGH 0

`endif

// ---- hw/pwmd_sync.sv ----
`timescale 1ns/1ns

module pwmd_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // asynchronous levels in
   input wire logic [WIDTH-1:0] async_in,
   // filtered levels out
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_reg; // metastability catcher, read only by stage2
   logic [WIDTH-1:0] stage2_reg; // second stage
   logic [WIDTH-1:0] stage3_reg; // third stage
   logic [WIDTH-1:0] out_reg; // accepted level
   logic [WIDTH-1:0] out_next; // accepted level, next

   // ------------------------------------------------------------
   // accept a change only once stages two and three agree
   // ------------------------------------------------------------
   assign out_next = (stage2_reg == stage3_reg) ? stage3_reg : out_reg;
   assign sync_out = out_reg;

   // shift chain
   always_ff @(posedge clock) begin
      if (srst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         out_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         out_reg <= out_next;
      end
   end

endmodule : pwmd_sync

// ---- hw/pwmd_top.sv ----
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
`include "pwmd_regs.svh"

module pwmd_top import pwmd_pkg::*; #(
   parameter int COUNT_W = 7,
   parameter int ADDR_W = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // mode from the pwm control register
   input wire logic pwm_enhanced,
   input wire logic [1:0] output_config_select,
   input wire logic [1:0] pair_polarity_select,
   // scheduled levels from duty and steering logic
   input wire logic pwm_raw,
   input wire logic [3:0] bridge_steer,
   input wire logic period_match,
   // pin direction latches, one means input
   input wire logic [3:0] pin_direction,
   // shutdown sources
   input wire logic cmp1_out,
   input wire logic cmp2_out,
   input wire logic fault_input_n,
   // output pins
   output logic out_a,
   output logic out_b,
   output logic out_c,
   output logic out_d,
   output logic out_a_oe_n,
   output logic out_b_oe_n,
   output logic out_c_oe_n,
   output logic out_d_oe_n
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0] del_reg; // restart enable and dead-band count
   logic [7:0] del_next; // dead-band register, next
   logic [6:0] as_cfg_reg; // source select and pair states
   logic [6:0] as_cfg_next; // shutdown config, next
   logic status_reg; // shutdown status
   logic status_next; // shutdown status, next
   logic run_reg; // pwm allowed in this period
   logic run_next; // run flag, next
   logic [7:0] rdata_reg; // read data, one cycle after strobe
   logic [7:0] rdata_next; // read data, next
   logic [3:0] level_reg; // registered normal pin levels
   logic [3:0] level_next; // normal pin levels, next

   wire del_sel = (reg_addr == `PWMD_DEL_ADDR); // dead-band register hit
   wire as_sel = (reg_addr == `PWMD_AS_ADDR); // shutdown register hit
   wire del_wr = reg_wr & del_sel; // write to dead-band register
   wire as_wr = reg_wr & as_sel; // write to shutdown register

   wire restart_en = del_reg[`PWMD_RESTART_BIT]; // auto-restart enable
   wire [COUNT_W-1:0] dead_band_count = del_reg[`PWMD_COUNT_MSB:`PWMD_COUNT_LSB];
   wire [2:0] src_sel = as_cfg_reg[`PWMD_SRC_MSB:`PWMD_SRC_LSB];
   wire [1:0] ac_state = as_cfg_reg[`PWMD_AC_MSB:`PWMD_AC_LSB];
   wire [1:0] bd_state = as_cfg_reg[`PWMD_BD_MSB:`PWMD_BD_LSB];

   pwmd_cfg_type cfg; // decoded output configuration
   assign cfg = pwmd_cfg_type'(output_config_select);
   wire half_mode = pwm_enhanced & (cfg == pwmd_cfg_half);

   // ------------------------------------------------------------
   // shutdown sources, all active high inside
   // ------------------------------------------------------------
   logic [2:0] src_raw; // straight from the pins
   logic [2:0] src_sync; // filtered onto the clock
   always_comb begin
      src_raw = 3'h0;
      src_raw[`PWMD_SRC_CMP1] = cmp1_out;
      src_raw[`PWMD_SRC_CMP2] = cmp2_out;
      src_raw[`PWMD_SRC_FAULT] = ~fault_input_n;
   end

   // three-stage filter before the status bit sees a source
   pwmd_sync #(
      .WIDTH(3)
   ) u_sync (
      .clock(clock),
      .srst(srst),
      .async_in(src_raw),
      .sync_out(src_sync)
   );

   // asynchronous cause drives the pins, synchronous one the status
   wire cause_async = pwm_enhanced & pwmd_src_hit(src_sel, src_raw);
   wire cause_sync = pwm_enhanced & pwmd_src_hit(src_sel, src_sync);

   // ------------------------------------------------------------
   // status and period gating
   // ------------------------------------------------------------
   // cause wins over any write or auto clear
   assign status_next = cause_sync ? 1'b1 :
                        as_wr ? reg_wdata[`PWMD_STATUS_BIT] :
                        (restart_en & status_reg) ? 1'b0 :
                        status_reg;
   // run flag only changes to one at a period boundary
   assign run_next = period_match ? ~status_reg :
                     (status_reg ? 1'b0 : run_reg);

   wire shut_any = pwm_enhanced & (cause_async | status_reg | ~run_reg);

   // ------------------------------------------------------------
   // register writes and reads
   // ------------------------------------------------------------
   assign del_next = del_wr ? reg_wdata : del_reg;
   assign as_cfg_next = as_wr ? reg_wdata[6:0] : as_cfg_reg;
   assign rdata_next = !reg_rd ? 8'h00 :
                       del_sel ? del_reg :
                       as_sel ? {status_reg, as_cfg_reg} :
                       8'h00; // unmapped reads zero

   // configuration registers
   always_ff @(posedge clock) begin
      if (srst) begin
         del_reg <= `PWMD_DEL_RESET;
         as_cfg_reg <= 7'(`PWMD_AS_RESET);
      end else begin
         del_reg <= del_next;
         as_cfg_reg <= as_cfg_next;
      end
   end

   // status, run flag and read data
   always_ff @(posedge clock) begin
      if (srst) begin
         status_reg <= 1'b0;
         run_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         status_reg <= status_next;
         run_reg <= run_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ------------------------------------------------------------
   // scheduled active levels per configuration
   // ------------------------------------------------------------
   logic [3:0] sched; // order d c b a
   always_comb begin
      case (cfg)
         pwmd_cfg_single: begin
            sched = {3'h0, pwm_raw};
         end
         pwmd_cfg_half: begin
            sched = {2'h0, ~pwm_raw, pwm_raw};
         end
         pwmd_cfg_full_fwd, pwmd_cfg_full_rev: begin
            sched = bridge_steer;
         end
         default: begin
            sched = 4'h0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // dead-band delay per output
   // ------------------------------------------------------------
   logic [3:0] delayed; // active level after dead-band
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_db
         pwmd_deadband #(
            .COUNT_W(COUNT_W)
         ) u_db (
            .clock(clock),
            .srst(srst),
            .enable(half_mode),
            .count(dead_band_count),
            .sched(sched[gi]),
            .actual(delayed[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // polarity: a one in the select bit makes that pair active low
   // ------------------------------------------------------------
   wire pol_ac = pair_polarity_select[1]; // a/c pair
   wire pol_bd = pair_polarity_select[0]; // b/d pair
   assign level_next = delayed ^ {pol_bd, pol_ac, pol_bd, pol_ac};

   // normal pin levels
   always_ff @(posedge clock) begin
      if (srst) begin
         level_reg <= 4'h0;
      end else begin
         level_reg <= level_next;
      end
   end

   // ------------------------------------------------------------
   // pin stage: shutdown override bypasses the clock
   // ------------------------------------------------------------
   wire ac_tri = ac_state[`PWMD_STATE_TRI]; // a/c float in shutdown
   wire bd_tri = bd_state[`PWMD_STATE_TRI]; // b/d float in shutdown
   wire ac_lvl = pwmd_shut_level(ac_state);
   wire bd_lvl = pwmd_shut_level(bd_state);

   assign out_a = shut_any ? ac_lvl : level_reg[0];
   assign out_c = shut_any ? ac_lvl : level_reg[2];
   assign out_b = shut_any ? bd_lvl : level_reg[1];
   assign out_d = shut_any ? bd_lvl : level_reg[3];
   // direction latches decide drive; shutdown may float a pair
   assign out_a_oe_n = pin_direction[0] | (shut_any & ac_tri);
   assign out_c_oe_n = pin_direction[2] | (shut_any & ac_tri);
   assign out_b_oe_n = pin_direction[1] | (shut_any & bd_tri);
   assign out_d_oe_n = pin_direction[3] | (shut_any & bd_tri);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking top_cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence sw_clear_s;
      as_wr && !reg_wdata[`PWMD_STATUS_BIT];
   endsequence

   status_set_a: assert property (cause_sync |=> status_reg)
      else $error("status not set by shutdown cause");
   write_ignored_a: assert property ((cause_sync and sw_clear_s) |=> status_reg)
      else $error("status cleared while cause active");
   force_shut_a: assert property (as_wr && reg_wdata[7] |=> status_reg ##0 shut_any)
      else $error("writing one did not force shutdown");
   auto_clear_a: assert property (status_reg && restart_en && !cause_sync && !as_wr
      |=> !status_reg)
      else $error("auto-restart did not clear status");
   manual_hold_a: assert property (status_reg && !restart_en && !cause_sync && !as_wr
      |=> status_reg)
      else $error("status cleared without software");
   period_hold_a: assert property (period_match && status_reg |=> !run_reg [*1])
      else $error("pwm resumed in shutdown period");
   resume_wait_a: assert property (!run_reg && !period_match |=> !run_reg)
      else $error("pwm resumed mid-period");
   async_pin_a: assert property (cause_async && ac_state == 2'h0
      |-> !out_a && !out_c && !out_a_oe_n == !pin_direction[0])
      else $error("a/c pair not shut down at once");
   bd_high_a: assert property (shut_any && bd_state == 2'h1 |-> out_b && out_d)
      else $error("b/d pair not driven high");
   ac_tri_a: assert property (shut_any && ac_tri |-> out_a_oe_n && out_c_oe_n)
      else $error("a/c pair not floated");
   polarity_a: assert property (!shut_any && $past(!pol_ac && !pol_bd)
      && $stable(pair_polarity_select) |-> out_a == $past(delayed[0]))
      else $error("polarity not applied to a");
   src_off_a: assert property (src_sel == 3'h0 |-> !cause_async && !cause_sync)
      else $error("disabled select still causes shutdown");

endmodule : pwmd_top

// ---- sim/pwmd_bridge_model.sv ----
`timescale 1ns/1ns

// ------------------------------------------------------------
// switch driver stage with pull-downs on every pin
// ------------------------------------------------------------
module pwmd_bridge_model import pwmd_pkg::*; (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // pins as the block drives them
   input wire logic out_a,
   input wire logic out_b,
   input wire logic out_c,
   input wire logic out_d,
   input wire logic out_a_oe_n,
   input wire logic out_b_oe_n,
   input wire logic out_c_oe_n,
   input wire logic out_d_oe_n,
   // resolved wire levels
   output logic pin_a,
   output logic pin_b,
   output logic pin_c,
   output logic pin_d,
   // both switches of the a/b leg seen on together
   output logic shoot_seen
);
   // released pin falls to the pull-down, keeping the switch off
   assign pin_a = out_a_oe_n ? 1'b0 : out_a;
   assign pin_b = out_b_oe_n ? 1'b0 : out_b;
   assign pin_c = out_c_oe_n ? 1'b0 : out_c;
   assign pin_d = out_d_oe_n ? 1'b0 : out_d;

   // sticky flag for cross-conduction of the leg
   always_ff @(posedge clock) begin
      if (srst) begin
         shoot_seen <= 1'b0;
      end else if (pin_a & pin_b) begin
         shoot_seen <= 1'b1;
      end
   end
endmodule : pwmd_bridge_model

// ---- sim/test_pwm_deadband_autoshutdown.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin n_tests++; if ((sn) !== (ex)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, ex, sn); end end

module test_pwm_deadband_autoshutdown import pwmd_pkg::*;;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic pwm_enhanced = 1'b1;
   logic [1:0] output_config_select = 2'h0;
   logic [1:0] pair_polarity_select = 2'h0;
   logic pwm_raw = 1'b0;
   logic period_match = 1'b0;
   logic [3:0] pin_direction = 4'hf;
   logic cmp1_out = 1'b0;
   logic cmp2_out = 1'b0;
   logic fault_input_n = 1'b1;
   logic out_a, out_b, out_c, out_d;
   logic out_a_oe_n, out_b_oe_n, out_c_oe_n, out_d_oe_n;
   logic pin_a, pin_b, pin_c, pin_d, shoot_seen;
   int mismatches = 0;
   int n_tests = 0;
   logic [7:0] rdv;
   logic [2:0] sv;
   int s;

   always #10 clock = ~clock;

   // ------------------------------------------------------------
   // block and far side
   // ------------------------------------------------------------
   pwmd_top pwmd_top_i (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_enhanced(pwm_enhanced),
      .output_config_select(output_config_select), .pair_polarity_select(pair_polarity_select),
      .pwm_raw(pwm_raw), .bridge_steer(4'h0), .period_match(period_match), .pin_direction(pin_direction),
      .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .fault_input_n(fault_input_n), .out_a(out_a),
      .out_b(out_b), .out_c(out_c), .out_d(out_d), .out_a_oe_n(out_a_oe_n), .out_b_oe_n(out_b_oe_n),
      .out_c_oe_n(out_c_oe_n), .out_d_oe_n(out_d_oe_n));

   pwmd_bridge_model pwmd_bridge_model_i (.clock(clock), .srst(srst), .out_a(out_a), .out_b(out_b),
      .out_c(out_c), .out_d(out_d), .out_a_oe_n(out_a_oe_n), .out_b_oe_n(out_b_oe_n),
      .out_c_oe_n(out_c_oe_n), .out_d_oe_n(out_d_oe_n), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c),
      .pin_d(pin_d), .shoot_seen(shoot_seen));

   // ------------------------------------------------------------
   // bus and timing helpers
   // ------------------------------------------------------------
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   // read data sampled in the one cycle it stands
   task automatic chkreg(input logic [1:0] a, input logic [7:0] ex, input string nm);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      rdv = reg_rdata;
      `CHK(nm, ex, rdv)
   endtask : chkreg

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask : cyc

   // one period boundary, then settle
   task automatic pulse();
      @(posedge clock);
      period_match <= 1'b1;
      @(posedge clock);
      period_match <= 1'b0;
      cyc(2);
   endtask : pulse

   // rise and fall of the half-bridge drive with count c
   task automatic db(input int c);
      wr(2'h0, c[7:0]);
      cyc(c + 3);
      `CHK("b idle", 1'b1, out_b)
      @(posedge clock);
      pwm_raw <= 1'b1;
      for (int i = 0; i <= c + 1; i++) begin
         @(negedge clock);
         `CHK("a rise", (i > c), out_a)
         `CHK("b fall", (i == 0), out_b)
      end
      @(posedge clock);
      pwm_raw <= 1'b0;
      for (int i = 0; i <= c + 1; i++) begin
         @(negedge clock);
         `CHK("a fall", (i == 0), out_a)
         `CHK("b rise", (i > c), out_b)
      end
   endtask : db

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // watchdog against a hang
   initial begin
      #400000;
      mismatches++;
      summarize();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'he832));
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      chkreg(2'h0, 8'h00, "del rst");
      chkreg(2'h1, 8'h00, "as rst");
      // random fields, unmapped writes ignored
      for (int i = 0; i < 4; i++) begin
         sv = 3'($urandom);
         rdv = 8'($urandom);
         wr(2'h0, rdv);
         wr(2'h2, ~rdv);
         chkreg(2'h0, rdv, "del rw");
         chkreg(2'h2, 8'h00, "unmapped");
      end
      wr(2'h0, 8'h00);
      // full period before pins turn to outputs
      pulse();
      pulse();
      pin_direction <= 4'h0;
      // fault pin, restart off
      wr(2'h1, 8'h46);
      chkreg(2'h1, 8'h46, "as cfg");
      pulse();
      `CHK("a run", 1'b0, out_a)
      @(posedge clock);
      fault_input_n <= 1'b0;
      @(negedge clock);
      `CHK("a shut", 1'b1, out_a)
      `CHK("c shut", 1'b1, out_c)
      `CHK("b tri", 1'b1, out_b_oe_n)
      `CHK("d pin", 1'b0, pin_d)
      cyc(6);
      chkreg(2'h1, 8'hc6, "status set");
      wr(2'h1, 8'h46);
      chkreg(2'h1, 8'hc6, "clear refused");
      @(posedge clock);
      fault_input_n <= 1'b1;
      cyc(8);
      chkreg(2'h1, 8'hc6, "status held");
      pulse();
      `CHK("a period", 1'b1, out_a)
      wr(2'h1, 8'h46);
      chkreg(2'h1, 8'h46, "sw clear");
      `CHK("a wait", 1'b1, out_a)
      pulse();
      `CHK("a resume", 1'b0, out_a)
      // comparator level with restart on
      wr(2'h0, 8'h80);
      wr(2'h1, 8'h14);
      @(posedge clock);
      cmp1_out <= 1'b1;
      cyc(20);
      chkreg(2'h1, 8'h94, "level held");
      @(posedge clock);
      cmp1_out <= 1'b0;
      cyc(8);
      chkreg(2'h1, 8'h14, "auto clear");
      pulse();
      `CHK("a restart", 1'b0, out_a)
      // every select code against every source
      for (int i = 0; i < 24; i++) begin
         sv = 3'(i / 3);
         s = i % 3;
         wr(2'h1, {1'b0, sv, 4'h4});
         @(posedge clock);
         cmp1_out <= (s == 0);
         cmp2_out <= (s == 1);
         fault_input_n <= (s != 2);
         @(negedge clock);
         `CHK("src pin", sv[s], out_a)
         cyc(6);
         chkreg(2'h1, {sv[s], sv, 4'h4}, "src status");
         @(posedge clock);
         cmp1_out <= 1'b0;
         cmp2_out <= 1'b0;
         fault_input_n <= 1'b1;
         cyc(8);
         pulse();
         `CHK("src end", 1'b0, out_a)
      end
      // no shutdown outside enhanced modes
      wr(2'h1, 8'h44);
      @(posedge clock);
      pwm_enhanced <= 1'b0;
      fault_input_n <= 1'b0;
      @(negedge clock);
      `CHK("not enh", 1'b0, out_a)
      @(posedge clock);
      fault_input_n <= 1'b1;
      pwm_enhanced <= 1'b1;
      cyc(8);
      pulse();
      // software force
      wr(2'h0, 8'h00);
      wr(2'h1, 8'h84);
      @(negedge clock);
      `CHK("forced", 1'b1, out_a)
      chkreg(2'h1, 8'h84, "forced bit");
      wr(2'h1, 8'h04);
      pulse();
      `CHK("unforced", 1'b0, out_a)
      // dead-band in half-bridge mode
      @(posedge clock);
      output_config_select <= pwmd_cfg_half;
      db(0);
      db(1 + $urandom % 6);
      db(1 + $urandom % 6);
      wr(2'h0, 8'h05);
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         pwm_raw <= (i < 3);
         @(negedge clock);
         `CHK("short duty", 1'b0, out_a)
      end
      // no delay in single mode
      @(posedge clock);
      output_config_select <= pwmd_cfg_single;
      cyc(3);
      @(posedge clock);
      pwm_raw <= 1'b1;
      @(posedge clock);
      @(negedge clock);
      `CHK("single", 1'b1, out_a)
      @(posedge clock);
      pwm_raw <= 1'b0;
      // polarity per pair, pins released first
      pin_direction <= 4'hf;
      pair_polarity_select <= 2'b10;
      cyc(2);
      `CHK("ac low", 1'b1, out_a)
      `CHK("c low", 1'b1, out_c)
      `CHK("bd high", 1'b0, out_b)
      @(posedge clock);
      pair_polarity_select <= 2'b01;
      cyc(2);
      `CHK("ac high", 1'b0, out_a)
      `CHK("bd low", 1'b1, out_b)
      // second reset in mid-run
      @(posedge clock);
      srst <= 1'b1;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      chkreg(2'h0, 8'h00, "del rst2");
      chkreg(2'h1, 8'h00, "as rst2");
      `CHK("oe rst", 1'b1, out_a_oe_n)
      `CHK("shoot", 1'b0, shoot_seen)
      summarize();
   end
endmodule : test_pwm_deadband_autoshutdown
